/* File: core/swp_pkg.sv */
/*
  constants shared by the single-wire configuration loader: register offsets,
  field positions, reset values and timing figures.
  assumes a 50 MHz system clock on mclk.
*/
package swp_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int STORE_TIME_MS = 100;
    localparam int STORE_CYC = STORE_TIME_MS * (CLK_HZ / 1000);
    localparam int IDLE_TIME_US = 400;
    localparam int IDLE_CYC = IDLE_TIME_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 16;
    localparam int TMR_W = 23;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_GRANULARITY = 4'h5;
    localparam logic [3:0] OFS_REF_TRIM = 4'ha;
    localparam logic [3:0] OFS_CLOCK_MON = 4'hb;
    localparam logic [3:0] OFS_PROD_A = 4'hc;
    localparam logic [3:0] OFS_PROD_B = 4'hd;
    localparam logic [3:0] OFS_NV_CMD = 4'he;
    localparam logic [3:0] OFS_POSITION = 4'hf;
    localparam int BANK_DEPTH = 16;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_EDGE_STEP = 7;
    localparam int BIT_TRIM_LO = 5;
    localparam int BIT_CLK_SRC = 0;
    localparam int BIT_CLK_DLY = 2;
    localparam int BIT_VIEW_EN = 3;
    localparam int BIT_STORE = 6;
    localparam int BIT_RELOAD = 7;
    // ------------------------------------------------------------------
    // single-wire frame and nonvolatile commands
    // ------------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam int NV_ADDR_W = 3;
    localparam int NV_WORD_W = 32;
    localparam int NV_DEPTH = 8;
    localparam int NV_BANK_WORDS = 4;
    localparam logic [1:0] HEAD_REG_WRITE = 2'h0;
    localparam logic [3:0] NVC_ERASE_WRITE = 4'h4;
    localparam logic [3:0] NVC_BLK_ERASE_WRITE = 4'h5;
    localparam logic [3:0] NVC_WRITE = 4'h6;
    localparam logic [3:0] NVC_BLK_WRITE = 4'h7;
    localparam logic [3:0] NVC_ERASE = 4'he;
    localparam logic [3:0] NVC_BLK_ERASE = 4'hf;
    typedef enum {F_IDLE, F_HEAD, F_REG, F_ECMD, F_EADDR, F_EDATA, F_STOP} swp_frame_t;
    typedef enum {NV_LOAD, NV_IDLE, NV_COPY, NV_WAIT} swp_nv_t;
endpackage

/* File: core/swp_bit_rx.sv */
/*
  pulse-width bit receiver for the single-wire port.
  assumes an idle-high wire from an asynchronous source; two flops sync it.
*/
`timescale 1ns/100ps
module swp_bit_rx #(
    parameter int IDLE_CYC = swp_pkg::IDLE_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wireIn,
    output logic bitStb,
    output logic bitVal,
    output logic frameIdle
);
    // ------------------------------------------------------------------
    // synchroniser and phase timers
    // ------------------------------------------------------------------
    logic sync1_r, sync2_r, prev_r;
    logic inLow_r, inLow_nxt, busy_r, busy_nxt;
    logic [swp_pkg::CNT_W-1:0] lowLen_r, lowLen_nxt, cnt_r, cnt_nxt;
    logic stb_nxt, val_nxt, idle_nxt;
    logic fall, rise;

    assign fall = prev_r & ~sync2_r;
    assign rise = ~prev_r & sync2_r;

    // measure low then high phase; a bit closes at the next falling edge
    always_comb begin
        inLow_nxt = inLow_r;
        busy_nxt = busy_r;
        lowLen_nxt = lowLen_r;
        stb_nxt = 1'b0;
        val_nxt = 1'b0;
        idle_nxt = 1'b0;
        cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + 1'b1;
        if (fall) begin
            if (busy_r && !inLow_r) begin
                stb_nxt = 1'b1;
                val_nxt = (lowLen_r > cnt_r);
            end
            busy_nxt = 1'b1;
            inLow_nxt = 1'b1;
            cnt_nxt = '0;
        end else if (rise && busy_r) begin
            inLow_nxt = 1'b0;
            lowLen_nxt = cnt_r;
            cnt_nxt = '0;
        end else if (busy_r && !inLow_r && cnt_r == swp_pkg::CNT_W'(IDLE_CYC)) begin
            stb_nxt = 1'b1; // last bit ends in the idle high level
            val_nxt = (lowLen_r > cnt_r);
            idle_nxt = 1'b1;
            busy_nxt = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge mclk) begin
        sync1_r <= wireIn;
        sync2_r <= sync1_r;
        if (reset) begin
            prev_r <= 1'b1;
            inLow_r <= 1'b0;
            busy_r <= 1'b0;
            lowLen_r <= '0;
            cnt_r <= '0;
            bitStb <= 1'b0;
            bitVal <= 1'b0;
            frameIdle <= 1'b0;
        end else begin
            prev_r <= sync2_r;
            inLow_r <= inLow_nxt;
            busy_r <= busy_nxt;
            lowLen_r <= lowLen_nxt;
            cnt_r <= cnt_nxt;
            bitStb <= stb_nxt;
            bitVal <= val_nxt;
            frameIdle <= idle_nxt;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_bit_class;
        @(posedge mclk) disable iff (reset)
        (fall && busy_r && !inLow_r) |=> bitStb && (bitVal == $past(lowLen_r > cnt_r));
    endproperty
    a_bit_class: assert property (p_bit_class) else $error("bit class wrong");
endmodule

/* File: core/swp_config_core.sv */
/*
  single-wire configuration port, register bank and nonvolatile store/reload.
  assumes mclk at 50 MHz, synchronous reset, periodPosition on mclk.
*/
// Function
// - register frame: start 1, 00, addr, data, stop 0
// - start then four-bit nonvolatile command field
// - store bit starts copying bank into memory
// - store bit clears itself after completion
// - edge step select bit steers outputs
// - clock source select bit
// - clock delay insert bit
// - position view enable bit
// - position shown at readout register when enabled
// - reload bit and start-up reload, self-clearing
// - bits coded by low versus high width
// - code 0100 erases then writes one word
// - three-bit word address, 32 data bits
`timescale 1ns/100ps
module swp_config_core #(
    parameter int STORE_CYC = swp_pkg::STORE_CYC,
    parameter int IDLE_CYC = swp_pkg::IDLE_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic singleWirePort,
    input wire logic [7:0] periodPosition,
    input wire logic [3:0] rdAddr,
    output logic [7:0] rdData,
    output logic outputEdgeStepSelect,
    output logic [1:0] referenceTrim,
    output logic clockSourceSelect,
    output logic clockDelayInsert,
    output logic positionViewEnable,
    output logic storeBusy,
    output logic reloadBusy
);
    // ------------------------------------------------------------------
    // bit receiver
    // ------------------------------------------------------------------
    logic bitStb, bitVal, frameIdle;

    swp_bit_rx #(.IDLE_CYC(IDLE_CYC)) u_rx (
        .mclk(mclk),
        .reset(reset),
        .wireIn(singleWirePort),
        .bitStb(bitStb),
        .bitVal(bitVal),
        .frameIdle(frameIdle)
    );

    // ------------------------------------------------------------------
    // frame decoder
    // ------------------------------------------------------------------
    swp_pkg::swp_frame_t fst_r, fst_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [31:0] sh_r, sh_nxt, shIn;
    logic [3:0] cmd_r, cmd_nxt;
    logic [2:0] eAddr_r, eAddr_nxt;
    logic isReg_r, isReg_nxt;
    logic cmtReg, cmtNv;

    // a memory command that carries no data words
    function automatic logic noData(input logic [3:0] c);
        return c[3];
    endfunction

    assign shIn = {sh_r[30:0], bitVal};

    // shift bits msb first and walk the frame fields
    always_comb begin
        fst_nxt = fst_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        cmd_nxt = cmd_r;
        eAddr_nxt = eAddr_r;
        isReg_nxt = isReg_r;
        cmtReg = 1'b0;
        cmtNv = 1'b0;
        if (bitStb) begin
            sh_nxt = shIn;
            cnt_nxt = cnt_r + 6'h01;
            case (fst_r)
                swp_pkg::F_IDLE: begin
                    cnt_nxt = '0;
                    if (bitVal) fst_nxt = swp_pkg::F_HEAD;
                end
                swp_pkg::F_HEAD: begin
                    if (cnt_r == 6'h01) begin
                        cnt_nxt = '0;
                        cmd_nxt = {shIn[1:0], 2'h0};
                        isReg_nxt = (shIn[1:0] == swp_pkg::HEAD_REG_WRITE);
                        fst_nxt = isReg_nxt ? swp_pkg::F_REG : swp_pkg::F_ECMD;
                    end
                end
                swp_pkg::F_REG: begin
                    if (cnt_r == 6'(swp_pkg::REG_ADDR_W + swp_pkg::REG_DATA_W - 1)) begin
                        fst_nxt = swp_pkg::F_STOP;
                    end
                end
                swp_pkg::F_ECMD: begin
                    if (cnt_r == 6'h01) begin
                        cnt_nxt = '0;
                        cmd_nxt = {cmd_r[3:2], shIn[1:0]};
                        fst_nxt = swp_pkg::F_EADDR;
                    end
                end
                swp_pkg::F_EADDR: begin
                    if (cnt_r == 6'(swp_pkg::NV_ADDR_W - 1)) begin
                        cnt_nxt = '0;
                        eAddr_nxt = shIn[2:0];
                        fst_nxt = noData(cmd_r) ? swp_pkg::F_STOP : swp_pkg::F_EDATA;
                    end
                end
                swp_pkg::F_EDATA: begin
                    if (cnt_r == 6'(swp_pkg::NV_WORD_W - 1)) fst_nxt = swp_pkg::F_STOP;
                end
                swp_pkg::F_STOP: begin
                    sh_nxt = sh_r;
                    fst_nxt = swp_pkg::F_IDLE;
                    cmtReg = !bitVal && isReg_r;
                    cmtNv = !bitVal && !isReg_r;
                end
                default: fst_nxt = swp_pkg::F_IDLE;
            endcase
        end
        if (frameIdle) fst_nxt = swp_pkg::F_IDLE;
    end

    // frame decoder registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            fst_r <= swp_pkg::F_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            cmd_r <= '0;
            eAddr_r <= '0;
            isReg_r <= 1'b0;
        end else begin
            fst_r <= fst_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            cmd_r <= cmd_nxt;
            eAddr_r <= eAddr_nxt;
            isReg_r <= isReg_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register bank, nonvolatile array and store/reload sequencer
    // ------------------------------------------------------------------
    logic [7:0] bank_r [swp_pkg::BANK_DEPTH];
    logic [7:0] bank_nxt [swp_pkg::BANK_DEPTH];
    logic [31:0] nvMem [swp_pkg::NV_DEPTH] = '{default: 32'h0}; // erased array reads as zero
    swp_pkg::swp_nv_t nst_r, nst_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [swp_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
    logic [7:0] nvWe;
    logic [31:0] nvWd [swp_pkg::NV_DEPTH];
    logic [3:0] wAddr;
    logic [7:0] wData;
    logic [31:0] curWord;

    assign wAddr = sh_r[11:8];
    assign wData = sh_r[7:0];
    assign curWord = nvMem[eAddr_r];

    // sequencer: boot reload, register writes, store copy and its timer
    always_comb begin
        bank_nxt = bank_r;
        nst_nxt = nst_r;
        idx_nxt = idx_r;
        tmr_nxt = tmr_r;
        nvWe = '0;
        for (int i = 0; i < swp_pkg::NV_DEPTH; i++) nvWd[i] = nvMem[i];
        case (nst_r)
            swp_pkg::NV_LOAD: begin
                for (int b = 0; b < 4; b++) bank_nxt[{idx_r, 2'(b)}] = nvMem[idx_r][8*b+:8];
                idx_nxt = idx_r + 2'h1;
                if (idx_r == 2'(swp_pkg::NV_BANK_WORDS - 1)) begin
                    bank_nxt[swp_pkg::OFS_NV_CMD][swp_pkg::BIT_RELOAD] = 1'b0;
                    bank_nxt[swp_pkg::OFS_NV_CMD][swp_pkg::BIT_STORE] = 1'b0;
                    nst_nxt = swp_pkg::NV_IDLE;
                end
            end
            swp_pkg::NV_IDLE: begin
                idx_nxt = '0;
                tmr_nxt = '0;
                // a 4-bit index always fits the bank, so a zero upper nibble is the full check
                if (cmtReg && sh_r[15:12] == 4'h0) begin
                    bank_nxt[wAddr] = wData;
                    if (wAddr == swp_pkg::OFS_NV_CMD && wData[swp_pkg::BIT_RELOAD]) begin
                        nst_nxt = swp_pkg::NV_LOAD;
                    end else if (wAddr == swp_pkg::OFS_NV_CMD && wData[swp_pkg::BIT_STORE]) begin
                        nst_nxt = swp_pkg::NV_COPY;
                    end
                end
                if (cmtNv) begin
                    case (cmd_r)
                        swp_pkg::NVC_ERASE_WRITE: begin
                            nvWe[eAddr_r] = 1'b1;
                            nvWd[eAddr_r] = sh_r;
                        end
                        swp_pkg::NVC_WRITE: begin
                            nvWe[eAddr_r] = 1'b1;
                            nvWd[eAddr_r] = curWord | sh_r;
                        end
                        swp_pkg::NVC_ERASE: begin
                            nvWe[eAddr_r] = 1'b1;
                            nvWd[eAddr_r] = '0;
                        end
                        swp_pkg::NVC_BLK_ERASE_WRITE, swp_pkg::NVC_BLK_WRITE,
                        swp_pkg::NVC_BLK_ERASE: begin
                            nvWe = 8'hff;
                            for (int i = 0; i < swp_pkg::NV_DEPTH; i++) begin
                                nvWd[i] = noData(cmd_r) ? '0 : sh_r;
                            end
                        end
                        default: nvWe = '0; // read and reserved codes do nothing here
                    endcase
                end
            end
            swp_pkg::NV_COPY: begin
                nvWe[idx_r] = 1'b1;
                for (int b = 0; b < 4; b++) nvWd[idx_r][8*b+:8] = bank_r[{idx_r, 2'(b)}];
                // command byte sits in byte 2 of word 3; its two command bits are not stored
                if (idx_r == 2'(swp_pkg::OFS_NV_CMD >> 2)) nvWd[idx_r][23:22] = 2'h0;
                idx_nxt = idx_r + 2'h1;
                tmr_nxt = tmr_r + 1'b1;
                if (idx_r == 2'(swp_pkg::NV_BANK_WORDS - 1)) nst_nxt = swp_pkg::NV_WAIT;
            end
            swp_pkg::NV_WAIT: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r >= swp_pkg::TMR_W'(STORE_CYC - 1)) begin
                    bank_nxt[swp_pkg::OFS_NV_CMD][swp_pkg::BIT_STORE] = 1'b0;
                    nst_nxt = swp_pkg::NV_IDLE;
                end
            end
            default: nst_nxt = swp_pkg::NV_IDLE;
        endcase
    end

    // bank, sequencer and outputs; reset starts the boot reload
    always_ff @(posedge mclk) begin
        for (int i = 0; i < swp_pkg::NV_DEPTH; i++) begin
            if (nvWe[i]) nvMem[i] <= nvWd[i];
        end
        if (reset) begin
            for (int i = 0; i < swp_pkg::BANK_DEPTH; i++) bank_r[i] <= swp_pkg::BANK_RESET;
            nst_r <= swp_pkg::NV_LOAD;
            idx_r <= '0;
            tmr_r <= '0;
            rdData <= 8'h00;
            outputEdgeStepSelect <= 1'b0;
            referenceTrim <= 2'h0;
            clockSourceSelect <= 1'b0;
            clockDelayInsert <= 1'b0;
            positionViewEnable <= 1'b0;
            storeBusy <= 1'b0;
            reloadBusy <= 1'b1;
        end else begin
            bank_r <= bank_nxt;
            nst_r <= nst_nxt;
            idx_r <= idx_nxt;
            tmr_r <= tmr_nxt;
            if (rdAddr == swp_pkg::OFS_POSITION && positionViewEnable) begin
                rdData <= periodPosition;
            end else begin
                rdData <= bank_r[rdAddr];
            end
            outputEdgeStepSelect <= bank_r[swp_pkg::OFS_GRANULARITY][swp_pkg::BIT_EDGE_STEP];
            referenceTrim <= bank_r[swp_pkg::OFS_REF_TRIM][swp_pkg::BIT_TRIM_LO+:2];
            clockSourceSelect <= bank_r[swp_pkg::OFS_CLOCK_MON][swp_pkg::BIT_CLK_SRC];
            clockDelayInsert <= bank_r[swp_pkg::OFS_CLOCK_MON][swp_pkg::BIT_CLK_DLY];
            positionViewEnable <= bank_r[swp_pkg::OFS_CLOCK_MON][swp_pkg::BIT_VIEW_EN];
            storeBusy <= (nst_nxt == swp_pkg::NV_COPY) || (nst_nxt == swp_pkg::NV_WAIT);
            reloadBusy <= (nst_nxt == swp_pkg::NV_LOAD);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    property p_boot_load;
        $fell(reset) |-> nst_r == swp_pkg::NV_LOAD ##4 nst_r == swp_pkg::NV_IDLE;
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("no boot reload");
    property p_reload_clear;
        nst_r == swp_pkg::NV_LOAD && idx_r == 2'h3 |=> !bank_r[14][7] ##1 !reloadBusy;
    endproperty
    a_reload_clear: assert property (p_reload_clear) else $error("reload bit stuck");
    property p_store_start;
        nst_r == swp_pkg::NV_IDLE && cmtReg && sh_r[15:0] == 16'h0e40 |=> ##4 nvMem[3][22] == 1'b0 && storeBusy;
    endproperty
    a_store_start: assert property (p_store_start) else $error("store not started");
    property p_store_clear;
        $fell(bank_r[14][6]) && $past(nst_r) != swp_pkg::NV_LOAD
            |-> $past(nst_r) == swp_pkg::NV_WAIT && $past(tmr_r) >= STORE_CYC - 1;
    endproperty
    a_store_clear: assert property (p_store_clear) else $error("store bit cleared early");
    property p_reg_frame;
        cmtReg && nst_r == swp_pkg::NV_IDLE && sh_r[15:12] == 4'h0
            |=> bank_r[$past(wAddr)] == $past(wData);
    endproperty
    a_reg_frame: assert property (p_reg_frame) else $error("register write lost");
    property p_nv_prog;
        nst_r == swp_pkg::NV_IDLE && cmtNv && cmd_r == 4'h4 |=> nvMem[$past(eAddr_r)] == $past(sh_r);
    endproperty
    a_nv_prog: assert property (p_nv_prog) else $error("word not programmed");
    property p_cfg_out;
        1'b1 |=> clockDelayInsert == $past(bank_r[11][2])
            && outputEdgeStepSelect == $past(bank_r[5][7]);
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("config bit not driven");
    property p_monitor;
        rdAddr == 4'hf && positionViewEnable |=> rdData == $past(periodPosition);
    endproperty
    a_monitor: assert property (p_monitor) else $error("position not shown");
    c_reg_write: cover property (cmtReg);
    c_nv_write: cover property (cmtNv && cmd_r == 4'h4);
    c_store_done: cover property ($fell(storeBusy));
    c_reload_cmd: cover property (nst_r == swp_pkg::NV_IDLE ##1 nst_r == swp_pkg::NV_LOAD);
endmodule

/* File: sim/swp_wire_host.sv */
/*
  programmer model driving the single-wire port with pulse-width coded frames.
  assumes the bench seeds the random generator; the wire idles high between frames.
*/
`timescale 1ns/100ps
module swp_wire_host #(
    parameter int IDLE_CYC = 200,
    parameter int NV_GAP = 100
) (
    input wire logic mclk,
    output logic wireOut
);
    // ----------------------------------------------------------------
    // bit and frame senders
    // ----------------------------------------------------------------
    initial wireOut = 1'b1;

    // one bit: low phase then high phase, long/short swapped by value
    task automatic send_bit(input logic b, input int k);
        @(posedge mclk);
        wireOut <= 1'b0;
        repeat ((b ? 12 : 4) * k) @(posedge mclk);
        wireOut <= 1'b1;
        repeat ((b ? 4 : 12) * k - 1) @(posedge mclk);
    endtask

    // msb first at a random speed, then idle long enough to close the frame
    task automatic send_frame(input logic [47:0] v, input int n);
        int k;
        k = 1 + ($urandom % 2);
        for (int i = n - 1; i >= 0; i--) begin
            send_bit(v[i], k);
        end
        repeat (IDLE_CYC + 20) @(posedge mclk);
    endtask

    // start, write head, address, data, stop; the last bit runs into idle and always
    // reads as zero, so a refused stop of one is followed by a trailing zero bit
    task automatic reg_frame(input logic [7:0] a, input logic [7:0] d, input logic s);
        if (s) send_frame(48'({1'b1, 2'b00, a, d, 2'b10}), 21);
        else send_frame(48'({1'b1, 2'b00, a, d, 1'b0}), 20);
    endtask

    // start, command, word address, data for writes, stop
    task automatic nv_frame(input logic [3:0] c, input logic [2:0] a, input logic [31:0] d);
        if (c[3] == 1'b0) begin
            send_frame(48'({1'b1, c, a, d, 1'b0}), 41);
            repeat (NV_GAP) @(posedge mclk);
        end else begin
            send_frame(48'({1'b1, c, a, 1'b0}), 9);
        end
    endtask
endmodule

/* File: sim/single_wire_config_and_nv_store_test.sv */
/*
  self-checking bench for swp_config_core with a bank and memory model.
  assumes swp_wire_host as the programmer and a 50 MHz mclk.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module single_wire_config_and_nv_store_test;
    localparam int ST = 50;
    localparam int IT = 200;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wireLine;
    logic [7:0] periodPosition = 8'h00;
    logic [3:0] rdAddr = 4'h0;
    logic [7:0] rdData;
    logic edgeSel, clkSrc, clock_delay_insert, viewEn, storeBusy, reloadBusy;
    logic [1:0] trim;
    int n_errors = 0;
    int n_compared = 0;
    int storeLen = 0;
    int storeRun = 0;
    logic [7:0] bank[16];
    logic [31:0] nv[8];

    swp_config_core #(.STORE_CYC(ST), .IDLE_CYC(IT)) i_dut (.mclk(mclk), .reset(reset),
        .singleWirePort(wireLine), .periodPosition(periodPosition), .rdAddr(rdAddr),
        .rdData(rdData), .outputEdgeStepSelect(edgeSel), .referenceTrim(trim),
        .clockSourceSelect(clkSrc), .clockDelayInsert(clock_delay_insert), .positionViewEnable(viewEn),
        .storeBusy(storeBusy), .reloadBusy(reloadBusy));
    swp_wire_host #(.IDLE_CYC(IT)) i_host (.mclk(mclk), .wireOut(wireLine));

    // ----------------------------------------------------------------
    // clock, position source, store length monitor, watchdog
    // ----------------------------------------------------------------
    initial forever #10 mclk = ~mclk;
    always @(posedge mclk) periodPosition <= 8'($urandom);
    always @(posedge mclk) begin
        if (storeBusy === 1'b1) begin
            storeRun <= storeRun + 1;
        end else if (storeRun != 0) begin
            storeLen <= storeRun;
            storeRun <= 0;
        end
    end
    initial begin
        repeat (90000) @(posedge mclk);
        n_errors++;
        final_report();
    end

    // ----------------------------------------------------------------
    // model and checking tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // software keeps trim and production bits at zero
    function automatic logic [7:0] legal(input logic [3:0] a, input logic [7:0] d);
        case (a)
            4'ha: return d & 8'h9f;
            4'hc: return d & 8'h01;
            4'hd: return 8'h00;
            4'he: return d & 8'h38;
            default: return d;
        endcase
    endfunction

    task automatic load_bank();
        for (int i = 0; i < 16; i++) bank[i] = nv[i / 4][8 * (i % 4) +: 8];
        bank[14][7:6] = 2'b00;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input logic s);
        int w;
        i_host.reg_frame(a, d, s);
        if (s == 1'b0 && a < 8'h10) begin
            bank[a[3:0]] = d;
            if (a == 8'h0e && d[7]) begin
                load_bank();
            end else if (a == 8'h0e && d[6]) begin
                for (int i = 0; i < 16; i++) nv[i / 4][8 * (i % 4) +: 8] = bank[i];
                nv[3][23:22] = 2'b00;
                bank[14][6] = 1'b0;
                w = 0;
                while (storeBusy !== 1'b0 && w < ST + 400) begin
                    @(posedge mclk);
                    w++;
                end
                repeat (2) @(posedge mclk);
                `CHK(storeLen >= ST - 1 && storeLen <= ST + 1, 1'b1)
            end
        end
    endtask

    task automatic rd_check(input logic [3:0] a);
        logic [7:0] p;
        @(posedge mclk);
        rdAddr <= a;
        #1 p = periodPosition;
        @(posedge mclk);
        #1;
        if (a == 4'hf && bank[11][3]) `CHK(rdData, p)
        else `CHK(rdData, bank[a])
    endtask

    task automatic check_all();
        for (int i = 0; i < 16; i++) rd_check(4'(i));
        `CHK(edgeSel, bank[5][7])
        `CHK(trim, bank[10][6:5])
        `CHK(clkSrc, bank[11][0])
        `CHK(clock_delay_insert, bank[11][2])
        `CHK(viewEn, bank[11][3])
        `CHK({storeBusy, reloadBusy}, 2'b00)
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [3:0] a;
        logic [3:0] cmds[8];
        logic [2:0] na;
        logic [31:0] nd;
        cmds = '{4'h4, 4'h6, 4'he, 4'h5, 4'hf, 4'h7, 4'hc, 4'hd};
        void'($urandom(32'h45df));
        for (int i = 0; i < 16; i++) bank[i] = 8'h00;
        for (int i = 0; i < 8; i++) nv[i] = 32'h0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (10) @(posedge mclk);
        check_all();
        // random configuration, then refused frames
        repeat (12) begin
            a = 4'($urandom);
            reg_write({4'h0, a}, legal(a, 8'($urandom)), 1'b0);
        end
        reg_write(8'h0b, 8'h08 | 8'($urandom & 8'h05), 1'b0);
        reg_write(8'h15, 8'h3c, 1'b0);
        reg_write(8'h05, ~bank[5], 1'b1);
        check_all();
        // store, scramble, reload with both command bits set
        reg_write(8'h0e, 8'h40, 1'b0);
        check_all();
        repeat (4) begin
            a = 4'($urandom % 14);
            reg_write({4'h0, a}, legal(a, 8'($urandom)), 1'b0);
        end
        reg_write(8'h0e, 8'hc0, 1'b0);
        check_all();
        // every memory command, each followed by a reload
        foreach (cmds[i]) begin
            na = 3'($urandom % 4);
            nd = $urandom;
            i_host.nv_frame(cmds[i], na, nd);
            case (cmds[i])
                4'h4: nv[na] = nd;
                4'h6: nv[na] = nv[na] | nd;
                4'he: nv[na] = 32'h0;
                4'h5, 4'h7: foreach (nv[j]) nv[j] = nd;
                4'hf: foreach (nv[j]) nv[j] = 32'h0;
                default: ;
            endcase
            reg_write(8'h0e, 8'h80, 1'b0);
            check_all();
        end
        // reset mid-run reloads the stored image
        @(posedge mclk);
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        load_bank();
        repeat (10) @(posedge mclk);
        check_all();
        final_report();
    end
endmodule
